// >>> hdl/tdb_pkg.sv
// What this block does
// (R1) base offset field in control bits 4:0
// (R2) burst length field bits 12:8, count plus one
// (R3) port access goes to base+index word
// (R4) index advances by hardware within burst length
// (R5) sixteen or eight bit transfers via port
// (R6) byte mode: high byte first, low second
// (R7) data port forwards, stores nothing itself
// (R8) index wraps to zero after last transfer
`default_nettype none
package tdb_pkg;
    localparam logic [7:0]  TDB_OFS_CTRL     = 8'h48;
    localparam logic [7:0]  TDB_OFS_PORT     = 8'h4C;
    localparam logic [7:0]  TDB_OFS_MODE     = 8'h50;
    localparam logic [7:0]  TDB_TMR_CTRL_ONE = 8'h00;
    localparam int          TDB_BASE_LSB     = 0;
    localparam int          TDB_LEN_LSB      = 8;
    localparam int          TDB_IDX_LSB      = 8;
    localparam int          TDB_BYTE_BIT     = 0;
    localparam logic [4:0]  TDB_BASE_RST     = 5'h00;
    localparam logic [4:0]  TDB_LEN_RST      = 5'h00;
    localparam logic        TDB_BYTE_RST     = 1'b0;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
    } tdb_tgt_req_t;

    typedef enum logic [1:0] {
        TDB_ST_IDLE,
        TDB_ST_HI,
        TDB_ST_LO,
        TDB_ST_DONE
    } tdb_state_t;
endpackage : tdb_pkg
`default_nettype wire

// >>> hdl/tdb_burst_port.sv
`timescale 1ns/1ps
`default_nettype none
module tdb_burst_port
    import tdb_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         rst_b_i,
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [7:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output var  logic [31:0]  prdata_o,
    output var  logic         pready_o,
    output var  logic         pslverr_o,
    output var  tdb_tgt_req_t tgt_req_o,
    input  wire logic [15:0]  tgt_rdata_i
);
    logic [4:0]   base_r;
    logic [4:0]   len_r;
    logic         byte_mode_r;
    logic [4:0]   idx_r;
    tdb_state_t   state_r;
    tdb_tgt_req_t tgt_r;
    logic [31:0]  prdata_r;

    logic         setup;
    logic         sel_ctrl;
    logic         sel_port;
    logic         sel_mode;
    logic         done;
    logic [5:0]   count;
    logic [5:0]   idx_sum;
    logic [7:0]   tgt_addr;
    logic [5:0]   word_ofs;

    assign setup    = psel_i & ~penable_i;
    assign sel_ctrl = (paddr_i == TDB_OFS_CTRL);
    assign sel_port = (paddr_i == TDB_OFS_PORT);
    assign sel_mode = (paddr_i == TDB_OFS_MODE);
    assign count    = {1'b0, len_r} + 6'h01;                                    // R2
    assign idx_sum  = {1'b0, idx_r} + (byte_mode_r ? 6'h02 : 6'h01);
    assign word_ofs = {1'b0, base_r} + {1'b0, idx_r};
    assign tgt_addr = TDB_TMR_CTRL_ONE + {word_ofs, 2'b00};                     // R3

    // port accesses wait for the target cycles; own registers answer at once
    assign pready_o  = psel_i & penable_i & (~sel_port | (state_r == TDB_ST_DONE));
    assign pslverr_o = pready_o & ~(sel_ctrl | sel_port | sel_mode);
    assign done      = pready_o & sel_port;
    assign prdata_o  = prdata_r;
    assign tgt_req_o = tgt_r;

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            base_r      <= TDB_BASE_RST;
            len_r       <= TDB_LEN_RST;
            byte_mode_r <= TDB_BYTE_RST;
        end
        else if (pready_o && pwrite_i && sel_ctrl)
        begin
            base_r <= pwdata_i[TDB_BASE_LSB +: 5];                             // R1
            len_r  <= pwdata_i[TDB_LEN_LSB +: 5];                              // R2
        end
        else if (pready_o && pwrite_i && sel_mode)
        begin
            byte_mode_r <= pwdata_i[TDB_BYTE_BIT];                             // R5
        end
    end

    // a reprogrammed burst always starts again at the base offset
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            idx_r <= 5'h00;
        else if (pready_o && pwrite_i && sel_ctrl)
            idx_r <= 5'h00;
        else if (done)
        begin
            // an odd count in byte mode wraps one register past the end
            if (idx_sum >= count)
                idx_r <= 5'h00;                                                // R8
            else
                idx_r <= idx_sum[4:0];                                         // R4
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_r <= TDB_ST_IDLE;
        else
        begin
            case (state_r)
                TDB_ST_IDLE:
                    if (setup && sel_port)
                        state_r <= TDB_ST_HI;
                TDB_ST_HI:
                    state_r <= byte_mode_r ? TDB_ST_LO : TDB_ST_DONE;          // R6
                TDB_ST_LO:
                    state_r <= TDB_ST_DONE;
                default:
                    if (done || !psel_i)
                        state_r <= TDB_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tgt_r <= '0;
        else if (state_r == TDB_ST_IDLE && setup && sel_port)
        begin
            tgt_r.addr  <= tgt_addr;                                           // R3
            tgt_r.wdata <= byte_mode_r ? {8'h00, pwdata_i[15:8]} : pwdata_i[15:0];
            tgt_r.we    <= pwrite_i;
            tgt_r.re    <= ~pwrite_i;
        end
        else if (state_r == TDB_ST_HI && byte_mode_r)
        begin
            tgt_r.addr  <= tgt_r.addr + 8'h04;                                 // R6
            tgt_r.wdata <= {8'h00, pwdata_i[7:0]};
            tgt_r.we    <= pwrite_i;
            tgt_r.re    <= ~pwrite_i;
        end
        else
        begin
            tgt_r.we <= 1'b0;
            tgt_r.re <= 1'b0;
        end
    end

    // the port holds no value: reads return what the target gives back
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            prdata_r <= 32'h0000_0000;
        else if (state_r == TDB_ST_HI)
            prdata_r <= byte_mode_r ? {16'h0000, tgt_rdata_i[7:0], 8'h00}
                                    : {16'h0000, tgt_rdata_i};                  // R7
        else if (state_r == TDB_ST_LO)
            prdata_r[7:0] <= tgt_rdata_i[7:0];                                 // R6
        else if (setup && sel_ctrl)
            prdata_r <= {16'h0000, 3'b000, len_r, 3'b000, base_r};
        else if (setup && sel_mode)
            prdata_r <= {16'h0000, 3'b000, idx_r, 7'h00, byte_mode_r};
        else if (setup)
            prdata_r <= 32'h0000_0000;
    end

    // address, strobe, write data and latency properties start at the setup edge launching the target cycle; the others at a control write, a state or done
    chk_base_field: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R1
        (pready_o && pwrite_i && sel_ctrl) |=> base_r == $past(pwdata_i[4:0]))
        else $error("base offset not taken from write");
    chk_len_field: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R2
        (pready_o && pwrite_i && sel_ctrl) |=> len_r == $past(pwdata_i[12:8]))
        else $error("burst length not taken from write");
    chk_tgt_address: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R3
        (state_r == TDB_ST_IDLE && setup && sel_port) |=>
        tgt_r.addr == TDB_TMR_CTRL_ONE
            + ({3'b000, $past(base_r)} + {3'b000, $past(idx_r)}) * 8'h04)
        else $error("target address wrong");
    chk_idx_step: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R4
        (done && !byte_mode_r && ({1'b0, idx_r} + 6'h01 < count)) |=>
        idx_r == $past(idx_r) + 5'h01)
        else $error("burst index did not advance");
    chk_idx_pair: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R4
        (done && byte_mode_r && ({1'b0, idx_r} + 6'h02 < count)) |=>
        idx_r == $past(idx_r) + 5'h02)
        else $error("burst index did not advance by two");
    chk_idx_wrap: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R8
        (done && idx_sum >= count) |=> idx_r == 5'h00)
        else $error("burst index did not wrap");
    chk_port_latency: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R5
        (state_r == TDB_ST_IDLE && setup && sel_port) ##1 penable_i[*1] |->
        !pready_o ##[1:2] pready_o)
        else $error("port answer out of window");
    chk_word_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R5
        (state_r == TDB_ST_IDLE && setup && sel_port && pwrite_i && !byte_mode_r) |=>
        tgt_r.we && !tgt_r.re && tgt_r.wdata == $past(pwdata_i[15:0]))
        else $error("word write not forwarded");
    chk_byte_first: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R6
        (state_r == TDB_ST_IDLE && setup && sel_port && pwrite_i && byte_mode_r) |=>
        tgt_r.we && tgt_r.wdata == {8'h00, $past(pwdata_i[15:8])})
        else $error("first byte not the high half");
    chk_byte_split: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R6
        (state_r == TDB_ST_HI && byte_mode_r && pwrite_i) |=>
        tgt_r.we && tgt_r.addr == $past(tgt_r.addr) + 8'h04
        && tgt_r.wdata[7:0] == $past(pwdata_i[7:0]))
        else $error("byte split wrong");
    chk_read_strobe: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R7
        (state_r == TDB_ST_IDLE && setup && sel_port && !pwrite_i) |=> tgt_r.re && !tgt_r.we)
        else $error("port read not forwarded");
    chk_read_word: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R7
        (state_r == TDB_ST_HI && !pwrite_i && !byte_mode_r) |=>
        prdata_o == {16'h0000, $past(tgt_rdata_i)})
        else $error("read data not taken from target");
    chk_read_bytes: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R6
        (state_r == TDB_ST_LO && !pwrite_i) |=>
        prdata_o[7:0] == $past(tgt_rdata_i[7:0]) && prdata_o[15:8] == $past(prdata_o[15:8]))
        else $error("byte read halves wrong");
    chk_idle_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R5
        (state_r == TDB_ST_IDLE) |-> !tgt_r.we && !tgt_r.re)
        else $error("target strobe outside a port access");
    chk_port_nostore: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // R7
        done |=> $stable(base_r) && $stable(len_r) && $stable(byte_mode_r))
        else $error("port access changed stored state");

    cov_word_write: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        done && pwrite_i && !byte_mode_r);
    cov_byte_read: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        done && !pwrite_i && byte_mode_r);
    cov_wrap: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        done && idx_sum >= count && len_r != 5'h00);
    cov_byte_write: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        done && pwrite_i && byte_mode_r);
    cov_word_read: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
        done && !pwrite_i && !byte_mode_r);
endmodule : tdb_burst_port
`default_nettype wire

// >>> tb/tdb_tgt_model.sv
`timescale 1ns/1ps
`default_nettype none
module tdb_tgt_model
    import tdb_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire tdb_tgt_req_t req_i,
    output var  logic [15:0]  rdata_o
);
    logic [15:0] mem [64];
    initial
    begin
        for (int k = 0; k < 64; k++) mem[k] = 16'h0000;
    end
    // word address from byte address, as a real timer map decodes it
    always @(posedge mclk_i) if (req_i.we) mem[req_i.addr[7:2]] <= req_i.wdata;
    // outside a read strobe the data lines show the inverted stored word, never the stored value
    assign rdata_o = req_i.re ? mem[req_i.addr[7:2]] : ~mem[req_i.addr[7:2]];
endmodule : tdb_tgt_model
`default_nettype wire

// >>> tb/timer_dma_burst_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer_dma_burst_port_tb_top
    import tdb_pkg::*;
;
    logic         mclk, rst_b, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, seed, q;
    logic [15:0]  trd;
    tdb_tgt_req_t req;
    int           n_fail, checks;

    tdb_burst_port DUT (.mclk_i(mclk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tgt_req_o(req), .tgt_rdata_i(trd));
    tdb_tgt_model tgt (.mclk_i(mclk), .req_i(req), .rdata_o(trd));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [31:0] port_exp(input logic [5:0] a, input logic byt);
        if (byt) return {16'h0000, tgt.mem[a][7:0], tgt.mem[a + 6'h01][7:0]};
        return {16'h0000, tgt.mem[a]};
    endfunction : port_exp

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // one apb transfer; an idle edge follows so the next setup never collides
    // a missing pready is left to the watchdog, the wait itself has no limit
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    initial
    begin
        #80000;
        n_fail++;
        wrap_up();
    end

    initial
    begin
        int         n, step;
        logic [4:0] base, len, idx;
        logic [5:0] a;
        logic       byt;
        logic [31:0] v;
        n_fail = 0; checks = 0; seed = 32'h0000002F;
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h00000000;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        apb(1'b0, TDB_OFS_CTRL, 32'h0, q, e); chk(q, 32'h0);
        apb(1'b0, TDB_OFS_MODE, 32'h0, q, e); chk(q, 32'h0);
        apb(1'b1, 8'h54, xs(), q, e);
        chk(32'(e), 32'h1);
        apb(1'b0, 8'h54, 32'h0, q, e); chk(q, 32'h0); chk(32'(e), 32'h1);
        for (int r = 0; r < 4; r++)
        begin
            v = xs(); byt = r[0]; base = v[4:0];
            len = (r == 0) ? 5'h11 : v[12:8];
            n = int'(len) + 1; step = byt ? 2 : 1; idx = 5'h00;
            apb(1'b1, TDB_OFS_CTRL, {19'h0, len, 3'h0, base}, q, e);
            apb(1'b0, TDB_OFS_CTRL, 32'h0, q, e); chk(q, {19'h0, len, 3'h0, base});
            apb(1'b1, TDB_OFS_MODE, {31'h0, byt}, q, e);
            for (int i = 0; i <= n / step + 1; i++)
            begin
                v = xs(); a = 6'(base) + 6'(idx);
                apb(v[31], TDB_OFS_PORT, v, q, e);
                if (!v[31]) chk(q, port_exp(a, byt));
                else if (byt) chk(32'(tgt.mem[a][7:0]), 32'(v[15:8]));
                else chk(32'(tgt.mem[a]), 32'(v[15:0]));
                if (v[31] && byt) chk(32'(tgt.mem[a + 6'h01][7:0]), 32'(v[7:0]));
                idx = (int'(idx) + step >= n) ? 5'h00 : 5'(int'(idx) + step);
                apb(1'b0, TDB_OFS_MODE, 32'h0, q, e); chk(q, {19'h0, idx, 7'h0, byt});
            end
        end
        wrap_up();
    end
endmodule : timer_dma_burst_port_tb_top
`default_nettype wire
